/* hdl/brd_top.v */
// Function
// - Jumper routes socket address bit 15 or high in 64K fill
// - Whole ROM readable in both windows in 64K fill with jumper high
// - Writes to ROM windows give nonexistent memory
// - I-stream read of halt window enters halt
// - Other I-stream reads enter run mode
// - Writes and D-stream reads keep the mode
// - Retried fetches are not I-stream reads
// - Halt window answers 20040000 to 2004FFFF
// - Run window answers 20050000 to 2005FFFF
// - Small fills alias across each window
// - Run window returns halt window contents
// - Halts vector to 20040000
// - Supply and power good start execution
// - Longword, word and byte reads served
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "brd_regs.vh"

module brd_top
#(
  parameter ROM_WORDS = 16384
)
(
  // Clock and reset
  input  wire        CLK_SYS_I,
  input  wire        ARST_N_I,
  // Avalon-MM register slave
  input  wire [4:0]  AV_ADDRESS_I,
  input  wire        AV_READ_I,
  input  wire        AV_WRITE_I,
  input  wire [31:0] AV_WRITEDATA_I,
  output wire [31:0] AV_READDATA_O,
  output wire        AV_WAITREQUEST_O,
  // Processor local bus
  input  wire        LB_REQ_I,
  input  wire        LB_WR_I,
  input  wire [31:0] LB_ADDR_I,
  input  wire [3:0]  LB_BE_I,
  input  wire        LB_ISTREAM_I,
  input  wire        LB_RETRY_I,
  output wire        LB_ACK_O,
  output wire        LB_NXM_O,
  output wire [31:0] LB_RDATA_O,
  // Board and processor control
  input  wire        JUMPER_A14_I,
  input  wire        SUPPLY_GOOD_I,
  input  wire        POWER_GOOD_I,
  input  wire        EXT_HALT_I,
  output wire        CPU_HALT_O,
  output wire        CPU_RESET_N_O,
  output wire [31:0] HALT_VECTOR_O,
  output wire        RUN_LIGHT_O,
  output wire        IRQ_O
);

  reg  [31:0] rom_mem [0:ROM_WORDS-1];

  reg  [1:0]  fill_q;
  reg  [2:0]  status_q;
  reg  [2:0]  status_d;
  reg  [2:0]  mask_q;
  reg  [13:0] rom_ptr_q;
  reg         wait_q;
  reg  [31:0] av_rdata_q;
  reg  [31:0] av_rdata_d;
  reg         halt_mode_q;
  reg         halt_mode_d;
  reg         lb_ack_q;
  reg         lb_nxm_q;
  reg  [31:0] lb_word_q;
  reg  [3:0]  lb_be_q;
  reg  [31:0] lb_rdata_q;
  reg         cpu_halt_q;
  reg         cpu_reset_n_q;
  reg         armed_q;
  reg         run_light_q;
  reg         irq_q;
  reg  [31:0] vector_q;

  wire        hit_halt;
  wire        hit_run;
  wire [13:0] rom_idx;
  wire        hit_any;
  wire        istream_rd;
  wire        av_rd_done;
  wire        av_wr_done;
  wire [2:0]  av_reg;
  wire [2:0]  events;
  wire [31:0] lane_data;

  brd_rom_map u_map
  (
    .addr_i       (LB_ADDR_I),
    .fill_i       (fill_q),
    .jumper_a14_i (JUMPER_A14_I),
    .hit_halt_o   (hit_halt),
    .hit_run_o    (hit_run),
    .idx_o        (rom_idx)
  );

  assign hit_any = hit_halt | hit_run;
  // Retried fetches after an error count as data reads
  assign istream_rd = LB_REQ_I & ~LB_WR_I & LB_ISTREAM_I & ~LB_RETRY_I;

  // Mode tracking, only fetches and core reset move it
  always @*
  begin
    halt_mode_d = halt_mode_q;
    if (!cpu_reset_n_q)
    begin
      halt_mode_d = 1'b1;
    end
    else if (istream_rd)
    begin
      halt_mode_d = hit_halt;
    end
  end

  assign events[`BRD_EV_NXM]  = LB_REQ_I & LB_WR_I & hit_any;
  assign events[`BRD_EV_HALT] = halt_mode_d & ~halt_mode_q;
  assign events[`BRD_EV_RUN]  = ~halt_mode_d & halt_mode_q;

  always @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      halt_mode_q <= 1'b1;
      run_light_q <= 1'b0;
      cpu_halt_q  <= 1'b0;
    end
    else
    begin
      halt_mode_q <= halt_mode_d;
      run_light_q <= ~halt_mode_d;
      // External halt only reaches the core in run mode
      cpu_halt_q  <= EXT_HALT_I & ~halt_mode_d;
    end
  end

  // Local bus: answer one cycle after the request
  always @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      lb_ack_q  <= 1'b0;
      lb_nxm_q  <= 1'b0;
      lb_be_q   <= 4'h0;
    end
    else
    begin
      lb_ack_q <= LB_REQ_I & ~LB_WR_I & hit_any;
      lb_nxm_q <= LB_REQ_I & LB_WR_I & hit_any;
      lb_be_q  <= LB_BE_I;
    end
  end

  // Memory has no reset so it maps onto block RAM
  always @(posedge CLK_SYS_I)
  begin
    lb_word_q <= rom_mem[rom_idx];
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      // Disabled byte lanes return zero
      assign lane_data[8*g+7:8*g] = lb_be_q[g] ?
                                    lb_word_q[8*g+7:8*g] : 8'h00;
    end
  endgenerate

  // Read data registered one more stage to come from a flop
  always @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      lb_rdata_q <= 32'h00000000;
    end
    else if (lb_ack_q)
    begin
      lb_rdata_q <= lane_data;
    end
  end

  // Supply good low arms a fresh start from the halt vector
  always @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      armed_q       <= 1'b1;
      cpu_reset_n_q <= 1'b0;
      vector_q      <= `BRD_HALT_VECTOR;
    end
    else
    begin
      vector_q <= `BRD_HALT_VECTOR;
      if (!SUPPLY_GOOD_I)
      begin
        armed_q       <= 1'b1;
        cpu_reset_n_q <= 1'b0;
      end
      else if (armed_q && POWER_GOOD_I)
      begin
        armed_q       <= 1'b0;
        cpu_reset_n_q <= 1'b1;
      end
    end
  end

  // Avalon slave: one wait cycle, then a zero for one cycle
  // Fixed latency keeps the master's wait loop trivial
  assign av_reg     = AV_ADDRESS_I[`BRD_REG_MSB:`BRD_REG_LSB];
  assign av_rd_done = AV_READ_I & ~wait_q;
  assign av_wr_done = AV_WRITE_I & ~wait_q;

  always @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      wait_q <= 1'b1;
    end
    else
    begin
      wait_q <= ~((AV_READ_I | AV_WRITE_I) & wait_q);
    end
  end

  always @*
  begin
    av_rdata_d = 32'h00000000;
    case (av_reg)
      `BRD_OFS_CTRL:
        av_rdata_d[`BRD_FILL_MSB:`BRD_FILL_LSB] = fill_q;
      `BRD_OFS_STATUS:
        av_rdata_d[`BRD_EV_W-1:0] = status_q;
      `BRD_OFS_MASK:
        av_rdata_d[`BRD_EV_W-1:0] = mask_q;
      `BRD_OFS_MODE:
      begin
        av_rdata_d[`BRD_MODE_HALT]    = halt_mode_q;
        av_rdata_d[`BRD_MODE_JUMPER]  = JUMPER_A14_I;
        av_rdata_d[`BRD_MODE_SUPPLY]  = SUPPLY_GOOD_I;
        av_rdata_d[`BRD_MODE_POWER]   = POWER_GOOD_I;
        av_rdata_d[`BRD_MODE_CPU_RUN] = cpu_reset_n_q;
      end
      `BRD_OFS_ROM_PTR:
        av_rdata_d[`BRD_PTR_MSB:0] = rom_ptr_q;
      `BRD_OFS_ROM_DATA:
        av_rdata_d = rom_mem[rom_ptr_q];
      default:
        av_rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      av_rdata_q <= 32'h00000000;
    end
    else if (AV_READ_I && wait_q)
    begin
      av_rdata_q <= av_rdata_d;
    end
  end

  // Image loads only through the slave; the processor cannot write
  always @(posedge CLK_SYS_I)
  begin
    if (av_wr_done && av_reg == `BRD_OFS_ROM_DATA)
    begin
      rom_mem[rom_ptr_q] <= AV_WRITEDATA_I;
    end
  end

  // New events win over a clear in the same cycle
  always @*
  begin
    status_d = status_q;
    if (av_wr_done && av_reg == `BRD_OFS_STATUS)
    begin
      status_d = status_q & ~AV_WRITEDATA_I[`BRD_EV_W-1:0];
    end
    status_d = status_d | events;
  end

  always @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      fill_q    <= `BRD_CTRL_RESET;
      status_q  <= `BRD_EV_RESET;
      mask_q    <= `BRD_EV_RESET;
      rom_ptr_q <= `BRD_PTR_RESET;
      irq_q     <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);
      if (av_wr_done)
      begin
        case (av_reg)
          `BRD_OFS_CTRL:
            fill_q <= AV_WRITEDATA_I[`BRD_FILL_MSB:`BRD_FILL_LSB];
          `BRD_OFS_MASK:
            mask_q <= AV_WRITEDATA_I[`BRD_EV_W-1:0];
          `BRD_OFS_ROM_PTR:
            rom_ptr_q <= AV_WRITEDATA_I[`BRD_PTR_MSB:0];
          `BRD_OFS_ROM_DATA:
            rom_ptr_q <= rom_ptr_q + `BRD_PTR_ONE;
          default:
            rom_ptr_q <= rom_ptr_q;
        endcase
      end
      else if (av_rd_done && av_reg == `BRD_OFS_ROM_DATA)
      begin
        // Reads also step so an image can be dumped in one pass
        rom_ptr_q <= rom_ptr_q + `BRD_PTR_ONE;
      end
    end
  end

  assign AV_READDATA_O    = av_rdata_q;
  assign AV_WAITREQUEST_O = wait_q;
  assign LB_ACK_O         = lb_ack_q;
  assign LB_NXM_O         = lb_nxm_q;
  assign LB_RDATA_O       = lb_rdata_q;
  assign CPU_HALT_O       = cpu_halt_q;
  assign CPU_RESET_N_O    = cpu_reset_n_q;
  assign HALT_VECTOR_O    = vector_q;
  assign RUN_LIGHT_O      = run_light_q;
  assign IRQ_O            = irq_q;

endmodule

`default_nettype wire

/* hdl/brd_regs.vh */
`ifndef BRD_REGS_VH
`define BRD_REGS_VH

// Register numbers, taken from slave address bits 4 to 2
`define BRD_OFS_CTRL      3'h0
`define BRD_OFS_STATUS    3'h1
`define BRD_OFS_MASK      3'h2
`define BRD_OFS_MODE      3'h3
`define BRD_OFS_ROM_PTR   3'h4
`define BRD_OFS_ROM_DATA  3'h5

// Control register fields
`define BRD_FILL_LSB      0
`define BRD_FILL_MSB      1
`define BRD_FILL_16K      2'h0
`define BRD_FILL_32K      2'h1
`define BRD_FILL_64K      2'h2
`define BRD_CTRL_RESET    2'h2

// Register select and ROM pointer fields
`define BRD_REG_LSB       2
`define BRD_REG_MSB       4
`define BRD_PTR_MSB       13
`define BRD_PTR_ONE       14'h0001
`define BRD_PTR_RESET     14'h0000

// Status and mask bits
`define BRD_EV_NXM        0
`define BRD_EV_HALT       1
`define BRD_EV_RUN        2
`define BRD_EV_W          3
`define BRD_EV_RESET      3'h0

// Mode register bits
`define BRD_MODE_HALT     0
`define BRD_MODE_JUMPER   1
`define BRD_MODE_SUPPLY   2
`define BRD_MODE_POWER    3
`define BRD_MODE_CPU_RUN  4

// Local bus windows, upper 16 address bits
`define BRD_HALT_BASE     16'h2004
`define BRD_RUN_BASE      16'h2005
`define BRD_HALT_VECTOR   32'h20040000

// Byte address to longword index
`define BRD_IDX_LSB       2
`define BRD_IDX_MSB       15
`define BRD_IDX_A13       11
`define BRD_IDX_A14       12
`define BRD_IDX_A15       13
`define BRD_WIN_LSB       16
`define BRD_WIN_MSB       31

`endif

/* hdl/brd_rom_map.v */
`timescale 1ns/1ns
`default_nettype none
`include "brd_regs.vh"

module brd_rom_map
(
  // Reference
  input  wire [31:0] addr_i,
  input  wire [1:0]  fill_i,
  input  wire        jumper_a14_i,
  // Decode
  output reg         hit_halt_o,
  output reg         hit_run_o,
  output reg  [13:0] idx_o
);

  always @*
  begin
    hit_halt_o = (addr_i[`BRD_WIN_MSB:`BRD_WIN_LSB] == `BRD_HALT_BASE);
    hit_run_o  = (addr_i[`BRD_WIN_MSB:`BRD_WIN_LSB] == `BRD_RUN_BASE);
    // Same index for both windows, so run reads alias halt contents
    idx_o = addr_i[`BRD_IDX_MSB:`BRD_IDX_LSB];
    // Missing socket address bits read as tied high
    if (fill_i != `BRD_FILL_64K)
    begin
      idx_o[`BRD_IDX_A15] = 1'b1;
    end
    else if (!jumper_a14_i)
    begin
      idx_o[`BRD_IDX_A15] = 1'b1;
    end
    if (fill_i == `BRD_FILL_16K)
    begin
      idx_o[`BRD_IDX_A14] = 1'b1;
    end
  end

endmodule

`default_nettype wire

/* hdl/brd_top_note_placeholder.v */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* dv/brd_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module brd_chk
(
  // Clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        ARST_N_I,
  // Local bus
  input wire logic        LB_REQ_I,
  input wire logic        LB_WR_I,
  input wire logic [31:0] LB_ADDR_I,
  input wire logic        LB_ISTREAM_I,
  input wire logic        LB_RETRY_I,
  input wire logic        LB_ACK_O,
  input wire logic        LB_NXM_O,
  // Control
  input wire logic        SUPPLY_GOOD_I,
  input wire logic        CPU_RESET_N_O,
  input wire logic        CPU_HALT_O,
  input wire logic        RUN_LIGHT_O,
  input wire logic [31:0] HALT_VECTOR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  wire hw = LB_ADDR_I[31:16] == 16'h2004;
  wire win = hw || LB_ADDR_I[31:16] == 16'h2005;
  wire fetch = LB_REQ_I && LB_ISTREAM_I && !LB_RETRY_I && !LB_WR_I;
  // Supply loss forces halt, so mode rules only hold while live
  wire live = CPU_RESET_N_O && SUPPLY_GOOD_I;
  sequence s_wr; LB_REQ_I && LB_WR_I && win; endsequence
  sequence s_rd; LB_REQ_I && !LB_WR_I && win; endsequence
  sequence s_held; !CPU_RESET_N_O [*2]; endsequence
  AST_NXM: assert property (s_wr |=> LB_NXM_O && !LB_ACK_O)
    else $error("write not trapped");
  AST_ACK: assert property (s_rd |=> LB_ACK_O && !LB_NXM_O)
    else $error("read not answered");
  AST_HALT: assert property (fetch && hw && live |=> !RUN_LIGHT_O)
    else $error("halt not entered");
  AST_RUN: assert property (fetch && !hw && live |=> RUN_LIGHT_O)
    else $error("run not entered");
  AST_KEEP: assert property (!fetch && live |=> $stable(RUN_LIGHT_O))
    else $error("mode changed");
  AST_GATE: assert property (!RUN_LIGHT_O && !$past(RUN_LIGHT_O)
    && !$past(RUN_LIGHT_O, 2) |-> !CPU_HALT_O) else $error("halt leaked");
  AST_VEC: assert property (HALT_VECTOR_O == 32'h20040000)
    else $error("bad vector");
  AST_DROP: assert property (!SUPPLY_GOOD_I |=> !CPU_RESET_N_O)
    else $error("core not held");
  AST_HOLD: assert property (s_held |-> !RUN_LIGHT_O)
    else $error("run while held");
endmodule
bind brd_top brd_chk u_chk (.CLK_SYS_I, .ARST_N_I, .LB_REQ_I, .LB_WR_I,
  .LB_ADDR_I, .LB_ISTREAM_I, .LB_RETRY_I, .LB_ACK_O, .LB_NXM_O,
  .SUPPLY_GOOD_I, .CPU_RESET_N_O, .CPU_HALT_O, .RUN_LIGHT_O, .HALT_VECTOR_O);
`default_nettype wire

/* dv/brd_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module brd_cpu_model
(
  // Clock
  input  wire logic        clk_i,
  // Answer
  input  wire logic        ack_i,
  input  wire logic        nxm_i,
  input  wire logic [31:0] rdata_i,
  // Request
  output var  logic        req_o,
  output var  logic        wr_o,
  output var  logic [31:0] addr_o,
  output var  logic [3:0]  be_o,
  output var  logic        istream_o,
  output var  logic        retry_o
);
  initial
  begin
    {req_o, wr_o, istream_o, retry_o, be_o, addr_o} = '0;
  end
  // k is write, I-stream, retry; released lines show the inverse
  task automatic access(input logic [31:0] a, input logic [3:0] be,
    input logic [2:0] k, output logic [1:0] r, output logic [31:0] d);
  begin
    @(posedge clk_i);
    req_o <= 1'b1;
    {wr_o, istream_o, retry_o} <= k;
    addr_o <= a;
    be_o <= be;
    @(posedge clk_i);
    req_o <= 1'b0;
    addr_o <= ~a;
    {wr_o, istream_o, retry_o} <= ~k;
    @(posedge clk_i);
    r = {ack_i, nxm_i};
    @(posedge clk_i);
    d = rdata_i;
    @(negedge clk_i);
  end
  endtask
endmodule
`default_nettype wire

/* dv/brd_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
module brd_top_test;
  logic        CLK_SYS_I = 1'b0;
  logic        ARST_N_I = 1'b0;
  logic [4:0]  AV_ADDRESS_I = 5'h00;
  logic        AV_READ_I = 1'b0;
  logic        AV_WRITE_I = 1'b0;
  logic [31:0] AV_WRITEDATA_I = 32'h0;
  logic        JUMPER_A14_I = 1'b1;
  logic        SUPPLY_GOOD_I = 1'b1;
  logic        POWER_GOOD_I = 1'b1;
  logic        EXT_HALT_I = 1'b0;
  wire  [31:0] AV_READDATA_O, LB_ADDR_I, LB_RDATA_O, HALT_VECTOR_O;
  wire  [3:0]  LB_BE_I;
  wire         AV_WAITREQUEST_O, LB_REQ_I, LB_WR_I, LB_ISTREAM_I;
  wire         LB_RETRY_I, LB_ACK_O, LB_NXM_O, CPU_HALT_O;
  wire         CPU_RESET_N_O, RUN_LIGHT_O, IRQ_O;
  int          failures = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [31:0] d;
  logic [1:0]  r;
  brd_top uut (.CLK_SYS_I, .ARST_N_I, .AV_ADDRESS_I, .AV_READ_I, .AV_WRITE_I,
    .AV_WRITEDATA_I, .AV_READDATA_O, .AV_WAITREQUEST_O, .LB_REQ_I, .LB_WR_I,
    .LB_ADDR_I, .LB_BE_I, .LB_ISTREAM_I, .LB_RETRY_I, .LB_ACK_O, .LB_NXM_O,
    .LB_RDATA_O, .JUMPER_A14_I, .SUPPLY_GOOD_I, .POWER_GOOD_I, .EXT_HALT_I,
    .CPU_HALT_O, .CPU_RESET_N_O, .HALT_VECTOR_O, .RUN_LIGHT_O, .IRQ_O);
  brd_cpu_model cpu (.clk_i(CLK_SYS_I), .ack_i(LB_ACK_O), .nxm_i(LB_NXM_O),
    .rdata_i(LB_RDATA_O), .req_o(LB_REQ_I), .wr_o(LB_WR_I), .addr_o(LB_ADDR_I),
    .be_o(LB_BE_I), .istream_o(LB_ISTREAM_I), .retry_o(LB_RETRY_I));
  always #20 CLK_SYS_I = ~CLK_SYS_I;
  always @(posedge CLK_SYS_I)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
  begin
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] v);
  begin
    @(posedge CLK_SYS_I);
    AV_WRITE_I <= w;
    AV_READ_I <= !w;
    AV_ADDRESS_I <= a;
    AV_WRITEDATA_I <= v;
    do @(posedge CLK_SYS_I); while (AV_WAITREQUEST_O !== 1'b0);
    d = AV_READDATA_O;
    AV_WRITE_I <= 1'b0;
    AV_READ_I <= 1'b0;
  end
  endtask
  task automatic lb(input logic [31:0] a, input logic [2:0] k,
    input logic [3:0] be = 4'hF);
    cpu.access(a, be, k, r, d);
  endtask
  task automatic settle;
    repeat (3) @(negedge CLK_SYS_I);
  endtask
  task automatic t_reset;
  begin
    chk(RUN_LIGHT_O, 0);
    av(0, 5'h0C, 0);
    chk(d, 32'h1F);
    av(0, 5'h18, 0);
    chk(d, 0);
    $display("t_reset done");
  end
  endtask
  task automatic t_rom;
    logic [13:0] ix [3] = '{14'h0001, 14'h2001, 14'h3001};
  begin
    for (int i = 0; i < 3; i++)
    begin
      av(1, 5'h10, ix[i]);
      av(1, 5'h14, 32'hCAFE0000 | i);
    end
    av(1, 5'h10, 32'h3001);
    av(0, 5'h14, 0);
    chk(d, 32'hCAFE0002);
    av(0, 5'h10, 0);
    chk(d, 32'h3002);
    av(1, 5'h00, 0);
    for (int k = 0; k < 8; k++)
    begin
      lb(32'h20040004 + (k % 4) * 32'h4000 + (k / 4) * 32'h10000, 3'b000);
      chk(d, 32'hCAFE0002);
    end
    av(1, 5'h00, 1);
    lb(32'h20040004, 3'b000);
    chk(d, 32'hCAFE0001);
    av(1, 5'h00, 2);
    lb(32'h20050004, 3'b000);
    chk(d, 32'hCAFE0000);
    @(posedge CLK_SYS_I);
    JUMPER_A14_I <= 1'b0;
    lb(32'h20040004, 3'b000, 4'h1);
    chk(d, 32'h01);
    @(posedge CLK_SYS_I);
    JUMPER_A14_I <= 1'b1;
    $display("t_rom done");
  end
  endtask
  task automatic t_mode;
  begin
    @(posedge CLK_SYS_I);
    EXT_HALT_I <= 1'b1;
    lb(32'h20050000, 3'b010);
    chk(RUN_LIGHT_O, 1);
    settle;
    chk(CPU_HALT_O, 1);
    lb(32'h20040000, 3'b000);
    lb(32'h20040000, 3'b011);
    chk(RUN_LIGHT_O, 1);
    lb(32'h2004FFFC, 3'b100);
    chk(r, 2'b01);
    chk(RUN_LIGHT_O, 1);
    av(0, 5'h04, 0);
    chk(d, 32'h5);
    chk(IRQ_O, 0);
    av(1, 5'h08, 2);
    lb(32'h2004FFFC, 3'b010);
    chk(RUN_LIGHT_O, 0);
    settle;
    chk(CPU_HALT_O, 0);
    chk(IRQ_O, 1);
    av(1, 5'h04, 7);
    settle;
    chk(IRQ_O, 0);
    lb(32'h00001000, 3'b010);
    chk(r, 0);
    chk(RUN_LIGHT_O, 1);
    @(posedge CLK_SYS_I);
    EXT_HALT_I <= 1'b0;
    $display("t_mode done");
  end
  endtask
  task automatic t_power;
  begin
    @(posedge CLK_SYS_I);
    SUPPLY_GOOD_I <= 1'b0;
    POWER_GOOD_I <= 1'b0;
    settle;
    chk(CPU_RESET_N_O, 0);
    chk(RUN_LIGHT_O, 0);
    @(posedge CLK_SYS_I);
    SUPPLY_GOOD_I <= 1'b1;
    settle;
    chk(CPU_RESET_N_O, 0);
    @(posedge CLK_SYS_I);
    POWER_GOOD_I <= 1'b1;
    settle;
    chk(CPU_RESET_N_O, 1);
    chk(RUN_LIGHT_O, 0);
    chk(HALT_VECTOR_O, 32'h20040000);
    $display("t_power done");
  end
  endtask
  initial
  begin
    repeat (16) @(posedge CLK_SYS_I);
    ARST_N_I <= 1'b1;
    settle;
    t_reset;
    t_rom;
    t_mode;
    t_power;
    report_and_stop;
  end
endmodule
`default_nettype wire
